// File: design/kpi_pkg.sv
// ****************************************************************
// Keypad pin interrupt shared definitions
// ****************************************************************
package kpi_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned WB_ADR_W = 4;
  localparam int unsigned WB_DAT_W = 32;
  localparam int unsigned WB_SEL_W = 4;
  localparam int unsigned NUM_PINS = 6;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [WB_ADR_W-1:0] ADR_STATUS_CONTROL = 4'h0;
  localparam logic [WB_ADR_W-1:0] ADR_PIN_ENABLE = 4'h4;
  localparam logic [WB_ADR_W-1:0] ADR_PIN_POLARITY = 4'h8;
  localparam logic [WB_ADR_W-1:0] ADR_PIN_LEVEL = 4'hC;

  // ****************************************************************
  // Field positions in keypad_status_control
  // ****************************************************************
  localparam int unsigned BIT_EDGE_LEVEL_SELECT = 0;
  localparam int unsigned BIT_IRQ_MASK = 1;
  localparam int unsigned BIT_ACK_STROBE = 2;
  localparam int unsigned BIT_PENDING_FLAG = 3;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic RST_EDGE_LEVEL_SELECT = 1'b0;
  localparam logic RST_IRQ_MASK = 1'b0;
  localparam logic RST_LATCH = 1'b0;
  localparam logic [WB_DAT_W-1:0] RST_RD_DATA = 32'h0000_0000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [WB_ADR_W-1:0] adr;
    logic [WB_SEL_W-1:0] sel;
    logic [WB_DAT_W-1:0] dat;
  } kpi_wb_req_type;

  typedef struct packed {
    logic edge_level_select;
    logic irq_mask;
  } kpi_ctrl_type;

endpackage : kpi_pkg

// File: design/kpi_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module kpi_sync #(
  parameter int unsigned WIDTH = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;

  // Stage one is read only by stage two
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else if (i_clk_en) begin
      meta_r <= i_async;
      stage2_r <= meta_r;
      stage3_r <= stage2_r;
    end
  end

  // A bit moves only when stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      level_r <= '0;
    end else if (i_clk_en) begin
      level_r <= (stage2_r & stage3_r) | (level_r & (stage2_r ^ stage3_r));
    end
  end

  assign o_level = level_r;

endmodule : kpi_sync

// File: design/kpi_top.sv
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - Each pin has its own enable deciding whether it sets the latch.
// - Polarity 0 means falling or low, polarity 1 rising or high.
// - One shared bit selects edge-only or edge-and-level sensing.
// - Enabled pin gets pull-up for polarity 0, pull-down for 1.
// - Latch sets when an enabled input becomes asserted while no other is.
// - Edge-only: an edge is missed while another enabled input is asserted.
// - Edge-and-level: request stays while any enabled input is asserted.
// - Level mode clears only after inputs release and an acknowledge.
// - Vector fetch or writing 1 to acknowledge clears the latch.
// - Edges after an acknowledge latch a new request.
// - Request reaches the processor only while the mask is clear.
// - Reset clears the request and the sensitivity select bit.
// - Edge-only: acknowledge clears the latch at once.
// - Pending flag shows the request regardless of the mask.
// - Enable forces the pin to input; reads still need direction 0.
// - Pending flag is read-only, 1 while a request is pending.
// - Acknowledge bit is write-only and always reads 0.
// - Mask bit is read/write; 1 blocks requests.
// - Sensitivity bit is read/write; 1 selects edge and level.
module kpi_top #(
  parameter int unsigned NUM_PINS = kpi_pkg::NUM_PINS
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire kpi_pkg::kpi_wb_req_type i_wb_req,
  output logic [kpi_pkg::WB_DAT_W-1:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [NUM_PINS-1:0] i_pin,
  input wire logic [NUM_PINS-1:0] i_gpio_dir,
  input wire logic [NUM_PINS-1:0] i_gpio_out,
  output logic [NUM_PINS-1:0] o_pin_o,
  output logic [NUM_PINS-1:0] o_pin_oe,
  output logic [NUM_PINS-1:0] o_pull_up,
  output logic [NUM_PINS-1:0] o_pull_down,
  input wire logic i_vector_fetch,
  output logic o_irq_req
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int unsigned PAD_W = kpi_pkg::WB_DAT_W - NUM_PINS;

  kpi_pkg::kpi_ctrl_type ctrl_r;
  logic [NUM_PINS-1:0] pin_irq_enable_r;
  logic [NUM_PINS-1:0] pin_polarity_r;
  logic latch_r;
  logic any_asserted_q_r;
  logic ack_r;
  logic [kpi_pkg::WB_DAT_W-1:0] rd_data_r;
  logic [kpi_pkg::WB_DAT_W-1:0] rd_data_nxt;
  logic latch_nxt;

  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_asserted;
  logic any_asserted;
  logic edge_det;
  logic bus_take;
  logic bus_write;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_polarity;
  logic sw_ack;
  logic ack_event;
  logic pending_flag;
  logic [NUM_PINS-1:0] soft_read_level;

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Zero-extend a pin-wide value onto the bus
  function automatic logic [kpi_pkg::WB_DAT_W-1:0] pad_word(
    input logic [NUM_PINS-1:0] value
  );
    pad_word = {{PAD_W{1'b0}}, value};
  endfunction : pad_word

  // Write decode for one byte-wide register
  function automatic logic reg_hit(
    input logic take,
    input kpi_pkg::kpi_wb_req_type req,
    input logic [kpi_pkg::WB_ADR_W-1:0] offset
  );
    reg_hit = take && req.we && req.sel[0] && (req.adr == offset);
  endfunction : reg_hit

  // ****************************************************************
  // Pin input path
  // ****************************************************************
  // Pins are asynchronous, so they pass the filtered synchroniser
  kpi_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_async(i_pin),
    .o_level(pin_level)
  );

  // Asserted sense per pin, gated by its enable
  assign pin_asserted = pin_irq_enable_r & ~(pin_level ^ pin_polarity_r);
  assign any_asserted = |pin_asserted;

  // Previous combined sample for edge finding
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      any_asserted_q_r <= 1'b0;
    end else if (i_clk_en) begin
      any_asserted_q_r <= any_asserted;
    end
  end

  // Edge of the combined line: a held input hides others
  assign edge_det = any_asserted && !any_asserted_q_r;

  // ****************************************************************
  // Pad control
  // ****************************************************************
  // Enable selects the pull towards the idle level
  assign o_pull_up = pin_irq_enable_r & ~pin_polarity_r;
  assign o_pull_down = pin_irq_enable_r & pin_polarity_r;
  // Enabled pins never drive, whatever the direction says
  assign o_pin_oe = i_gpio_dir & ~pin_irq_enable_r;
  assign o_pin_o = i_gpio_out;
  // Software sees the pin only when its direction is input
  assign soft_read_level = (i_gpio_dir & i_gpio_out) | (~i_gpio_dir & pin_level);

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  // One wait state: answer in the cycle after the request appears
  assign bus_take = i_wb_req.cyc && i_wb_req.stb && !ack_r;
  assign bus_write = bus_take && i_wb_req.we;
  assign wr_ctrl = reg_hit(bus_take, i_wb_req, kpi_pkg::ADR_STATUS_CONTROL);
  assign wr_enable = reg_hit(bus_take, i_wb_req, kpi_pkg::ADR_PIN_ENABLE);
  assign wr_polarity = reg_hit(bus_take, i_wb_req, kpi_pkg::ADR_PIN_POLARITY);

  // Ack drops the cycle after it is given
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ack_r <= 1'b0;
    end else if (i_clk_en) begin
      ack_r <= bus_take;
    end
  end

  // Read mux; unmapped offsets answer with zero
  always_comb begin
    rd_data_nxt = kpi_pkg::RST_RD_DATA;
    case (i_wb_req.adr)
      kpi_pkg::ADR_STATUS_CONTROL: begin
        rd_data_nxt[kpi_pkg::BIT_EDGE_LEVEL_SELECT] = ctrl_r.edge_level_select;
        rd_data_nxt[kpi_pkg::BIT_IRQ_MASK] = ctrl_r.irq_mask;
        rd_data_nxt[kpi_pkg::BIT_ACK_STROBE] = 1'b0;
        rd_data_nxt[kpi_pkg::BIT_PENDING_FLAG] = pending_flag;
      end
      kpi_pkg::ADR_PIN_ENABLE: begin
        rd_data_nxt = pad_word(pin_irq_enable_r);
      end
      kpi_pkg::ADR_PIN_POLARITY: begin
        rd_data_nxt = pad_word(pin_polarity_r);
      end
      kpi_pkg::ADR_PIN_LEVEL: begin
        rd_data_nxt = pad_word(soft_read_level);
      end
      default: begin
        rd_data_nxt = kpi_pkg::RST_RD_DATA;
      end
    endcase
  end

  // Read data held in a flop, captured as the request is taken
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rd_data_r <= kpi_pkg::RST_RD_DATA;
    end else if (i_clk_en && bus_take && !i_wb_req.we) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // Data stays in the flop after ack so a slow master still sees it
  assign o_wb_dat = rd_data_r;
  assign o_wb_ack = ack_r;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Mode and mask; reset returns to edge-only, unmasked
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl_r.edge_level_select <= kpi_pkg::RST_EDGE_LEVEL_SELECT;
      ctrl_r.irq_mask <= kpi_pkg::RST_IRQ_MASK;
    end else if (i_clk_en && wr_ctrl) begin
      ctrl_r.edge_level_select <= i_wb_req.dat[kpi_pkg::BIT_EDGE_LEVEL_SELECT];
      ctrl_r.irq_mask <= i_wb_req.dat[kpi_pkg::BIT_IRQ_MASK];
    end
  end

  // Per-pin enables
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pin_irq_enable_r <= '0;
    end else if (i_clk_en && wr_enable) begin
      pin_irq_enable_r <= i_wb_req.dat[NUM_PINS-1:0];
    end
  end

  // Per-pin polarity
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pin_polarity_r <= '0;
    end else if (i_clk_en && wr_polarity) begin
      pin_polarity_r <= i_wb_req.dat[NUM_PINS-1:0];
    end
  end

  // ****************************************************************
  // Interrupt latch
  // ****************************************************************
  // Acknowledge from vector fetch or a written 1; the strobe is not stored
  assign sw_ack = wr_ctrl && i_wb_req.dat[kpi_pkg::BIT_ACK_STROBE];
  assign ack_event = i_vector_fetch || sw_ack;

  // Set beats clear so an edge during acknowledge is kept
  always_comb begin
    latch_nxt = latch_r;
    if (edge_det) begin
      latch_nxt = 1'b1;
    end else if (ack_event) begin
      latch_nxt = 1'b0;
    end
  end

  // Latch register; frozen with everything else while the enable is low
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      latch_r <= kpi_pkg::RST_LATCH;
    end else if (i_clk_en) begin
      latch_r <= latch_nxt;
    end
  end

  // Level mode keeps the request up while any input is held
  assign pending_flag = latch_r || (ctrl_r.edge_level_select && any_asserted);
  // Mask only gates the processor line, not the flag
  assign o_irq_req = pending_flag && !ctrl_r.irq_mask;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  irq_gate_a: assert property (pending_flag && !ctrl_r.irq_mask |-> o_irq_req)
    else $error("pending unmasked request not presented");

  mask_block_a: assert property (ctrl_r.irq_mask |-> !o_irq_req)
    else $error("masked request reached processor");

  edge_set_a: assert property (i_clk_en && edge_det |=> latch_r && pending_flag)
    else $error("edge did not set latch");

  held_block_a: assert property (i_clk_en && !latch_r && any_asserted_q_r |=> !latch_r)
    else $error("edge latched while another input held");

  level_hold_a: assert property (ctrl_r.edge_level_select && any_asserted |-> pending_flag)
    else $error("level request dropped while input asserted");

  level_keep_a: assert property (i_clk_en && latch_r && !ack_event |=> latch_r)
    else $error("latch cleared without acknowledge");

  edge_ack_a: assert property (i_clk_en && i_vector_fetch && !edge_det && !wr_ctrl
    && !ctrl_r.edge_level_select |=> !pending_flag)
    else $error("edge-only acknowledge did not clear");

  soft_ack_a: assert property (i_clk_en && wr_ctrl && !edge_det
    && i_wb_req.dat[kpi_pkg::BIT_ACK_STROBE] |=> !latch_r)
    else $error("software acknowledge did not clear latch");

  pull_sel_a: assert property ((o_pull_up & o_pull_down) == '0
    && (o_pull_up | o_pull_down) == pin_irq_enable_r)
    else $error("pull selection wrong");

  force_input_a: assert property ((o_pin_oe & pin_irq_enable_r) == '0)
    else $error("enabled pin driven");

  ack_read_a: assert property (i_clk_en && bus_take && !i_wb_req.we
    && i_wb_req.adr == kpi_pkg::ADR_STATUS_CONTROL
    |=> o_wb_ack && !o_wb_dat[kpi_pkg::BIT_ACK_STROBE])
    else $error("acknowledge bit read nonzero");

  reset_clear_a: assert property (disable iff (1'b0) i_reset
    |=> !latch_r && !ctrl_r.edge_level_select)
    else $error("reset left request or mode");

  // Register writes land at the take edge, reads show the state seen there
  flag_read_a: assert property (i_clk_en && bus_take && !i_wb_req.we
    && i_wb_req.adr == kpi_pkg::ADR_STATUS_CONTROL
    |=> o_wb_dat[kpi_pkg::BIT_PENDING_FLAG] == $past(pending_flag))
    else $error("pending flag read wrong");

  mode_write_a: assert property (i_clk_en && wr_ctrl
    |=> ctrl_r.edge_level_select == $past(i_wb_req.dat[kpi_pkg::BIT_EDGE_LEVEL_SELECT]))
    else $error("sensitivity bit not written");

  mask_write_a: assert property (i_clk_en && wr_ctrl
    |=> ctrl_r.irq_mask == $past(i_wb_req.dat[kpi_pkg::BIT_IRQ_MASK]))
    else $error("mask bit not written");

  enable_write_a: assert property (i_clk_en && wr_enable
    |=> pin_irq_enable_r == $past(i_wb_req.dat[NUM_PINS-1:0]))
    else $error("pin enables not written");

  polarity_write_a: assert property (i_clk_en && wr_polarity
    |=> pin_polarity_r == $past(i_wb_req.dat[NUM_PINS-1:0]))
    else $error("pin polarities not written");

  // In edge-only mode the flag is the latch and nothing else
  edge_only_a: assert property (!ctrl_r.edge_level_select |-> pending_flag == latch_r)
    else $error("edge-only flag follows pin level");

  set_wins_a: assert property (i_clk_en && ack_event && edge_det |=> latch_r)
    else $error("acknowledge swallowed a new edge");

  pin_read_a: assert property (i_clk_en && bus_take && !i_wb_req.we
    && i_wb_req.adr == kpi_pkg::ADR_PIN_LEVEL
    |=> (o_wb_dat[NUM_PINS-1:0] & ~$past(i_gpio_dir))
    == ($past(pin_level) & ~$past(i_gpio_dir)))
    else $error("input pin level read wrong");

  edge_int_c: cover property (edge_det && !ctrl_r.edge_level_select ##1 o_irq_req);
  level_int_c: cover property (ctrl_r.edge_level_select && any_asserted && !latch_r);
  fetch_ack_c: cover property (latch_r && i_vector_fetch ##1 !latch_r);
  bus_write_c: cover property (bus_write ##1 o_wb_ack);
  level_release_c: cover property (ctrl_r.edge_level_select && pending_flag && !latch_r
    ##1 !pending_flag);

endmodule : kpi_top

// File: sim/kpi_keypad_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Keypad switch bank seen from the pads
// ****************************************************************
module kpi_keypad_model #(
  parameter int unsigned NUM_PINS = 6
) (
  input wire logic i_ref_clk,
  input wire logic [NUM_PINS-1:0] i_press,
  input wire logic [NUM_PINS-1:0] i_act_high,
  input wire logic [NUM_PINS-1:0] i_pull_up,
  input wire logic [NUM_PINS-1:0] i_pull_down,
  input wire logic [NUM_PINS-1:0] i_pin_o,
  input wire logic [NUM_PINS-1:0] i_pin_oe,
  output logic [NUM_PINS-1:0] o_pin
);
  logic [NUM_PINS-1:0] float_r = '0;

  // Unpulled idle pins wander, so no stale level can pass for a real one
  always_ff @(posedge i_ref_clk) begin
    float_r <= ~float_r;
  end

  // Pad drive beats a closed key, which beats the pull devices
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (i_pin_oe[i]) begin
        o_pin[i] = i_pin_o[i];
      end else if (i_press[i]) begin
        o_pin[i] = i_act_high[i];
      end else if (i_pull_up[i]) begin
        o_pin[i] = 1'b1;
      end else if (i_pull_down[i]) begin
        o_pin[i] = 1'b0;
      end else begin
        o_pin[i] = float_r[i];
      end
    end
  end
endmodule : kpi_keypad_model

// File: sim/tb_kpi_top.sv
`timescale 1ns/1ps
module tb_kpi_top;
  localparam logic [3:0] SC = kpi_pkg::ADR_STATUS_CONTROL;
  localparam logic [3:0] EN = kpi_pkg::ADR_PIN_ENABLE;
  localparam logic [3:0] PO = kpi_pkg::ADR_PIN_POLARITY;
  localparam logic [3:0] LV = kpi_pkg::ADR_PIN_LEVEL;
  typedef struct packed {
    logic [5:0] en, pol, dir, up, dn, oe, lvl;
  } kpi_row_type;
  kpi_row_type rows [4] = '{
    '{6'h3F, 6'h00, 6'h3F, 6'h3F, 6'h00, 6'h00, 6'h2A},
    '{6'h3F, 6'h3F, 6'h00, 6'h00, 6'h3F, 6'h00, 6'h00},
    '{6'h00, 6'h15, 6'h3F, 6'h00, 6'h00, 6'h3F, 6'h2A},
    '{6'h0F, 6'h05, 6'h33, 6'h0A, 6'h05, 6'h30, 6'h2A}};
  logic ref_clk;
  logic rst = 1'b1;
  logic vec = 1'b0;
  logic clk_en = 1'b1;
  logic wb_ack;
  logic irq;
  logic [31:0] wb_dat;
  logic [31:0] rd;
  kpi_pkg::kpi_wb_req_type wb_req = '0;
  logic [5:0] pin, pin_o, pin_oe, pull_up, pull_down;
  logic [5:0] gpio_dir = 6'h00;
  logic [5:0] gpio_out = 6'h2A;
  logic [5:0] press = 6'h00;
  logic [5:0] act_high = 6'h04;
  int fail_count = 0;
  int check_count = 0;

  kpi_top u_dut (.i_ref_clk(ref_clk), .i_reset(rst), .i_clk_en(clk_en), .i_wb_req(wb_req),
    .o_wb_dat(wb_dat), .o_wb_ack(wb_ack), .i_pin(pin), .i_gpio_dir(gpio_dir),
    .i_gpio_out(gpio_out), .o_pin_o(pin_o), .o_pin_oe(pin_oe), .o_pull_up(pull_up),
    .o_pull_down(pull_down), .i_vector_fetch(vec), .o_irq_req(irq));

  kpi_keypad_model u_keys (.i_ref_clk(ref_clk), .i_press(press), .i_act_high(act_high),
    .i_pull_up(pull_up), .i_pull_down(pull_down), .i_pin_o(pin_o), .i_pin_oe(pin_oe),
    .o_pin(pin));

  // ****************************************************************
  // Clock and watchdog
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // About 350 cycles expected; a hang is cut off well beyond that
  initial begin
    #(25 * 5000);
    fail_count++;
    close_out();
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Classic single cycle; waits for ack, only the watchdog ends a hang
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge ref_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb_req <= '0;
  endtask : wb

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  // Pins need sync, filter and latch time before the flag moves
  task automatic keys(input logic [5:0] p);
    press <= p;
    idle(10);
  endtask : keys

  task automatic vfetch();
    @(posedge ref_clk);
    vec <= 1'b1;
    @(posedge ref_clk);
    vec <= 1'b0;
    idle(2);
  endtask : vfetch

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    idle(6);
    rst <= 1'b0;
    // Reset values, and an unused offset that must read zero
    wb(1'b0, SC, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b0, EN, 32'h0);
    chk(rd, 32'h0000_0000);
    wb(1'b0, 4'h1, 32'h0);
    chk(rd, 32'h0000_0000);
    // Table rows: pulls and pad direction follow enable and polarity
    foreach (rows[i]) begin
      gpio_dir <= rows[i].dir;
      wb(1'b1, EN, {26'h3FF_FFFF, rows[i].en});
      wb(1'b1, PO, {26'h3FF_FFFF, rows[i].pol});
      wb(1'b0, EN, 32'h0);
      chk(rd, {26'h0, rows[i].en});
      wb(1'b0, PO, 32'h0);
      chk(rd, {26'h0, rows[i].pol});
      wb(1'b0, LV, 32'h0);
      chk(rd, {26'h0, rows[i].lvl});
      chk(pull_up, rows[i].up);
      chk(pull_down, rows[i].dn);
      chk(pin_oe, rows[i].oe);
      chk(pin_o, 6'h2A);
    end
    gpio_dir <= 6'h00;
    wb(1'b1, EN, 32'h0);
    // Safe start: mask, polarity, enables, acknowledge, unmask
    wb(1'b1, SC, 32'h0000_0002);
    wb(1'b1, PO, 32'h0000_0004);
    wb(1'b1, EN, 32'h0000_0007);
    wb(1'b1, SC, 32'h0000_0006);
    wb(1'b1, SC, 32'h0000_0000);
    chk(irq, 1'b0);
    // Edge mode, falling pin: latch, mask, poll, acknowledge held pin
    keys(6'h01);
    chk(irq, 1'b1);
    wb(1'b0, SC, 32'h0);
    chk(rd, 32'h0000_0008);
    wb(1'b1, SC, 32'h0000_0002);
    chk(irq, 1'b0);
    wb(1'b0, SC, 32'h0);
    chk(rd, 32'h0000_000A);
    wb(1'b1, SC, 32'h0000_0006);
    wb(1'b0, SC, 32'h0);
    chk(rd, 32'h0000_0002);
    wb(1'b1, SC, 32'h0000_0000);
    // A second key while the first is held is lost
    keys(6'h03);
    wb(1'b0, SC, 32'h0);
    chk(rd, 32'h0000_0000);
    keys(6'h00);
    // Rising pin cleared by a vector fetch
    keys(6'h04);
    chk(irq, 1'b1);
    vfetch();
    chk(irq, 1'b0);
    keys(6'h00);
    chk(irq, 1'b0);
    // New edge after an acknowledge latches again
    keys(6'h01);
    wb(1'b1, SC, 32'h0000_0004);
    chk(irq, 1'b0);
    keys(6'h00);
    keys(6'h01);
    chk(irq, 1'b1);
    wb(1'b1, SC, 32'h0000_0004);
    keys(6'h00);
    // Disabled pin never requests
    keys(6'h08);
    chk(irq, 1'b0);
    keys(6'h00);
    // Frozen clock enable: a press is seen only once the enable returns
    clk_en <= 1'b0;
    keys(6'h01);
    chk(irq, 1'b0);
    clk_en <= 1'b1;
    idle(10);
    chk(irq, 1'b1);
    wb(1'b1, SC, 32'h0000_0004);
    keys(6'h00);
    chk(irq, 1'b0);
    // Level mode: acknowledge first, then release
    wb(1'b1, SC, 32'h0000_0001);
    wb(1'b0, SC, 32'h0);
    chk(rd, 32'h0000_0001);
    keys(6'h02);
    wb(1'b1, SC, 32'h0000_0005);
    idle(2);
    chk(irq, 1'b1);
    keys(6'h00);
    chk(irq, 1'b0);
    // Level mode: release first, then vector fetch
    keys(6'h02);
    keys(6'h00);
    chk(irq, 1'b1);
    vfetch();
    chk(irq, 1'b0);
    // Reset with a key held in level mode
    keys(6'h01);
    chk(irq, 1'b1);
    @(posedge ref_clk);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(1);
    chk(irq, 1'b0);
    wb(1'b0, SC, 32'h0);
    chk(rd, 32'h0000_0000);
    keys(6'h00);
    close_out();
  end
endmodule : tb_kpi_top
